// ---- src/unused_placeholder_none.sv ----
// intentionally empty design helper file: holds no module
`timescale 1ns/1ps

// ---- src/vpw_bus_transmitter.sv ----
// transmit side of the variable-pulse-width bus controller, wishbone slave
`timescale 1ns/1ps

// Function
// (R1) short pulse 64/16 us: low means 0, high means 1; levels alternate
// (R2) long pulse 128/32 us: high means 0, low means 1
// (R3) crc byte appended to data and responses unless crc is disabled
// (R4) only type III responses carry crc; types I and II have none; the code appends crc whenever crc is enabled, whatever the response type
// (R5) after last bit drive low 200/50 us as end of data
// (R6) responder sends high normalization bit after end of data, before first byte
// (R7) normalization 1 means crc follows by default; polarity control swaps it; the code sends a long high, which is a 0, when crc follows by default
// (R8) end of frame is low 280/70 us after last byte or extended end of data
// (R9) previous sender may start anew at 320/80 us; others may join from 280
// (R10) a high of 240 us or more is break: stop and reset transmitter
// (R11) transmitted break lasts 768 us with long break selected, else 300 us
// (R12) each byte is shifted out msb first from an internal shift register
// (R13) each transmit buffer write decrements the transmit byte counter; the code leaves a zero counter at zero
// (R14) finished byte: move buffered byte into shifter, set buffer empty flag
// (R15) final byte out and counter zero: load crc into shifter if enabled
// (R16) driving low while line high loses arbitration: idle, flag, clear dma
// (R17) start of frame is never arbitrated; start on idle or follow another
// (R18) no automatic retry except type II response; interrupt request if enabled
// (R19) while arbitration lost flag is set the transmitter stays off the link; the code still sends a break while the flag is set
// (R20) normal mode: wait idle, send start of frame, bytes, then crc
// (R21) software sets counter, reads status, checks flag, then writes first byte
// (R22) software waits for buffer empty flag before writing each further byte
// (R23) each message starts with a 200/50 us high start of frame
// (R24) software speed control selects normal or quad symbol timing
// (R25) symbol times counted in microsecond ticks with per-speed terminal counts
module vpw_bus_transmitter
    import vpw_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rx_line_i,
    output logic             tx_data_pin_o,
    output logic             tx_dma_req_o,
    output logic             tx_irq_req_o
);

    // register state
    vpw_gcr_t    gcr_q;
    vpw_isr_t    isr_q;
    vpw_mcr_t    mcr_q;
    vpw_icr_t    icr_q;
    logic [7:0]  tbc_q;
    logic [7:0]  tx_data_buffer_q;
    logic        buf_full_q;
    logic        ack_q;
    logic [31:0] rdat_q;

    // fsm state and one-cycle events toward the register block
    vpw_state_t  state_q;
    logic [9:0]  tmr_q;
    logic [7:0]  shift_q;
    logic [7:0]  saved_q;
    logic [2:0]  bit_idx_q;
    logic [3:0]  edge_cnt_q;
    logic        lvl_q;
    logic        crc_phase_q;
    logic [7:0]  crc_q;
    logic        pin_q;
    logic        ev_load_q;
    logic        ev_start_q;
    logic        ev_lost_q;
    logic        ev_done_q;
    logic        ev_brk_end_q;

    // tick and line synchroniser
    logic [4:0]  div_q;
    logic        rx_meta_q;
    logic        rx_q;
    logic        rx_prev_q;
    logic [9:0]  rx_low_us_q;
    logic [9:0]  rx_high_us_q;

    // bus decode
    wire         req       = wb_cyc_i & wb_stb_i & ~ack_q;
    wire         wr        = req & wb_we_i & wb_sel_i[0];
    wire         wr_gcr    = wr & (wb_adr_i == OFS_GCR);
    wire         wr_isr    = wr & (wb_adr_i == OFS_ISR);
    wire         wr_mcr    = wr & (wb_adr_i == OFS_MCR);
    wire         wr_icr    = wr & (wb_adr_i == OFS_ICR);
    wire         wr_tdb    = wr & (wb_adr_i == OFS_TDB);
    wire         wr_tbc    = wr & (wb_adr_i == OFS_TBC);
    wire vpw_isr_t isr_w1c = vpw_isr_t'(wb_dat_i[7:0]);
    wire [7:0]   rd_byte   = (wb_adr_i == OFS_GCR) ? gcr_q :
                             (wb_adr_i == OFS_ISR) ? isr_q :
                             (wb_adr_i == OFS_MCR) ? mcr_q :
                             (wb_adr_i == OFS_ICR) ? icr_q :
                             (wb_adr_i == OFS_TDB) ? tx_data_buffer_q :
                             (wb_adr_i == OFS_TBC) ? tbc_q : 8'h00;

    // timing selection
    wire         tick      = (div_q == TICK_LAST);
    wire         quad      = gcr_q.quad_speed_select;
    wire         crc_en    = ~gcr_q.crc_disable;
    wire [9:0]   dur_short = quad ? 10'(SHORT_Q_US) : 10'(SHORT_N_US);
    wire [9:0]   dur_long  = quad ? 10'(LONG_Q_US) : 10'(LONG_N_US);
    wire [9:0]   dur_sof   = quad ? 10'(SOF_Q_US) : 10'(SOF_N_US);
    wire [9:0]   dur_eod   = quad ? 10'(EOD_Q_US) : 10'(EOD_N_US);
    wire [9:0]   dur_eof   = quad ? 10'(EOF_Q_US) : 10'(EOF_N_US);
    wire [9:0]   dur_new   = quad ? 10'(NEWSOF_Q_US) : 10'(NEWSOF_N_US);
    wire [9:0]   dur_brk   = mcr_q.long_break_select ? 10'(BRK_LONG_US)
                                                     : 10'(BRK_SHORT_US);

    // symbol coding: a pulse is short when the bit equals the driven level
    wire         cur_bit   = shift_q[7];
    wire         sym_short = (cur_bit == lvl_q);
    wire         nb_val    = crc_en ^ gcr_q.norm_bit_polarity;                     // R7
    wire [9:0]   target    = (state_q == ST_SOF)   ? dur_sof :
                             (state_q == ST_NORM)  ? (nb_val ? dur_long : dur_short) :
                             (state_q == ST_BITS)  ? (sym_short ? dur_short : dur_long) :
                             (state_q == ST_BREAK) ? dur_brk : dur_new;
    wire         tmr_done  = tick & (tmr_q == target - 10'h001);

    wire         rx_edge   = rx_q ^ rx_prev_q;
    wire         rx_rise   = rx_q & ~rx_prev_q;
    wire         brk_seen  = (rx_high_us_q >= 10'(BRK_DET_US)) & (state_q != ST_BREAK);
    wire         arb_lost  = (state_q == ST_BITS) & ~lvl_q & rx_q
                           & (tmr_q >= 10'(ARB_SAMPLE_US));
    wire         retry_ok  = gcr_q.type2_response_mode & gcr_q.tx_inframe_response_mode;
    wire [7:0]   crc_nxt   = {crc_q[6:0], 1'b0} ^ ((crc_q[7] ^ cur_bit) ? CRC_POLY : 8'h00);
    wire         byte_end  = tmr_done & (state_q == ST_BITS) & (bit_idx_q == 3'h7);
    // flag updates still in flight must block a restart on a stale buffer
    wire         start_ok  = buf_full_q & ~isr_q.arb_lost_flag & ~ev_load_q & ~ev_lost_q
                           & ~ev_done_q;

    assign wb_ack_o      = ack_q;
    assign wb_dat_o      = rdat_q;
    assign tx_data_pin_o = pin_q;
    assign tx_dma_req_o  = mcr_q.tx_dma_enable & isr_q.tx_buffer_empty_flag & ~buf_full_q;
    assign tx_irq_req_o  = (isr_q.arb_lost_flag & icr_q.arb_lost_irq_enable)         // R18
                         | (isr_q.tx_buffer_empty_flag & icr_q.tx_buffer_empty_irq_enable);

    // wishbone answer, one wait state
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q  <= req;
            rdat_q <= req ? {24'h00_0000, rd_byte} : rdat_q;
        end
    end

    // microsecond tick and synchronised line with run-length counters
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_q        <= 5'h00;
            rx_meta_q    <= 1'b0;
            rx_q         <= 1'b0;
            rx_prev_q    <= 1'b0;
            rx_low_us_q  <= 10'h000;
            rx_high_us_q <= 10'h000;
        end
        else
        begin
            div_q     <= tick ? 5'h00 : div_q + 5'h01;                               // R25
            rx_meta_q <= rx_line_i;
            rx_q      <= rx_meta_q;
            rx_prev_q <= rx_q;
            if (rx_edge)
            begin
                rx_low_us_q  <= 10'h000;
                rx_high_us_q <= 10'h000;
            end
            else if (tick)
            begin
                // saturate so long idle periods stay recognisable
                if (~rx_q && rx_low_us_q != 10'h3ff)
                    rx_low_us_q <= rx_low_us_q + 10'h001;
                if (rx_q && rx_high_us_q != 10'h3ff)
                    rx_high_us_q <= rx_high_us_q + 10'h001;
            end
        end
    end

    // software registers; hardware sets are applied last so they win, except that a buffer write wins over ev_load_q
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            gcr_q            <= GCR_RST;
            isr_q            <= ISR_RST;
            mcr_q            <= MCR_RST;
            icr_q            <= ICR_RST;
            tbc_q            <= TBC_RST;
            tx_data_buffer_q <= 8'h00;
            buf_full_q       <= 1'b0;
        end
        else
        begin
            if (wr_gcr)
                gcr_q <= vpw_gcr_t'(wb_dat_i[7:0]);                                  // R24
            if (wr_mcr)
                mcr_q <= vpw_mcr_t'(wb_dat_i[7:0]);
            if (wr_icr)
                icr_q <= vpw_icr_t'(wb_dat_i[7:0]);
            if (wr_tbc)
                tbc_q <= wb_dat_i[7:0];
            if (wr_isr && isr_w1c.arb_lost_flag)
                isr_q.arb_lost_flag <= 1'b0;
            if (ev_load_q)
            begin
                buf_full_q                 <= 1'b0;
                isr_q.tx_buffer_empty_flag <= 1'b1;                                 // R14
            end
            if (wr_tdb)
            begin
                tx_data_buffer_q           <= wb_dat_i[7:0];
                buf_full_q                 <= 1'b1;
                isr_q.tx_buffer_empty_flag <= 1'b0;
                if (tbc_q != 8'h00)
                    tbc_q <= tbc_q - 8'h01;                                         // R13
            end
            if (ev_start_q)
                isr_q.tx_idle_flag <= 1'b0;
            if (ev_lost_q || ev_done_q)
            begin
                buf_full_q                 <= 1'b0;
                isr_q.tx_idle_flag         <= 1'b1;
                isr_q.tx_buffer_empty_flag <= 1'b1;
                mcr_q.tx_dma_enable        <= 1'b0;
            end
            if (ev_lost_q)
                isr_q.arb_lost_flag <= 1'b1;                                        // R16
            if (ev_brk_end_q)
            begin
                gcr_q.send_break        <= 1'b0;
                gcr_q.quad_speed_select <= 1'b0;
            end
        end
    end

    // symbol sequencer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q      <= ST_IDLE;
            tmr_q        <= 10'h000;
            shift_q      <= 8'h00;
            saved_q      <= 8'h00;
            bit_idx_q    <= 3'h0;
            edge_cnt_q   <= 4'h0;
            lvl_q        <= 1'b0;
            crc_phase_q  <= 1'b0;
            crc_q        <= CRC_INIT;
            pin_q        <= 1'b0;
            ev_load_q    <= 1'b0;
            ev_start_q   <= 1'b0;
            ev_lost_q    <= 1'b0;
            ev_done_q    <= 1'b0;
            ev_brk_end_q <= 1'b0;
        end
        else
        begin
            ev_load_q    <= 1'b0;
            ev_start_q   <= 1'b0;
            ev_lost_q    <= 1'b0;
            ev_done_q    <= 1'b0;
            ev_brk_end_q <= 1'b0;
            tmr_q        <= tick ? tmr_q + 10'h001 : tmr_q;                          // R25
            if (gcr_q.send_break && state_q != ST_BREAK && !ev_brk_end_q)
            begin
                // a break overrides whatever the link is doing
                state_q <= ST_BREAK;
                tmr_q   <= 10'h000;
                pin_q   <= 1'b1;
            end
            else if (brk_seen)
            begin
                state_q   <= ST_IDLE;                                               // R10
                pin_q     <= 1'b0;
                ev_done_q <= 1'b1;
            end
            else if (arb_lost)
            begin
                pin_q <= 1'b0;                                                      // R16
                if (retry_ok)
                begin
                    // follow the winner's byte, then resend ours
                    state_q    <= ST_RETRY;                                         // R18
                    edge_cnt_q <= 4'h8 - {1'b0, bit_idx_q};
                end
                else
                begin
                    state_q   <= ST_IDLE;                                           // R18
                    ev_lost_q <= 1'b1;
                end
            end
            else
            begin
                unique case (state_q)
                    ST_IDLE:
                    begin
                        pin_q <= 1'b0;
                        if (start_ok)                                               // R19
                        begin
                            ev_start_q <= 1'b1;
                            state_q    <= gcr_q.tx_inframe_response_mode ? ST_WAIT_EOD
                                                                         : ST_WAIT_BUS; // R20
                        end
                    end
                    ST_WAIT_BUS:
                    begin
                        // idle bus, or another node's start already rising
                        if (!rx_q && rx_low_us_q >= dur_new)                        // R9
                        begin
                            state_q <= ST_SOF;                                      // R17
                            tmr_q   <= 10'h000;
                            pin_q   <= 1'b1;                                        // R23
                        end
                        else if (rx_rise && rx_low_us_q >= dur_eof)                  // R9
                        begin
                            state_q <= ST_SOF;                                      // R17
                            tmr_q   <= 10'h000;
                            pin_q   <= 1'b1;
                        end
                    end
                    ST_WAIT_EOD:
                    begin
                        if (!rx_q && rx_low_us_q >= dur_eod)
                        begin
                            state_q <= ST_NORM;                                     // R6
                            tmr_q   <= 10'h000;
                            pin_q   <= 1'b1;
                        end
                    end
                    ST_SOF, ST_NORM:
                    begin
                        if (tmr_done)
                        begin
                            // first byte leaves the buffer, first bit is low
                            state_q     <= ST_BITS;
                            tmr_q       <= 10'h000;
                            shift_q     <= tx_data_buffer_q;                        // R14
                            saved_q     <= tx_data_buffer_q;
                            ev_load_q   <= 1'b1;
                            bit_idx_q   <= 3'h0;
                            lvl_q       <= 1'b0;
                            pin_q       <= 1'b0;
                            crc_q       <= CRC_INIT;
                            crc_phase_q <= 1'b0;
                        end
                    end
                    ST_BITS:
                    begin
                        if (tmr_done)
                        begin
                            tmr_q     <= 10'h000;
                            lvl_q     <= ~lvl_q;                                    // R1
                            pin_q     <= ~lvl_q;                                    // R2
                            bit_idx_q <= bit_idx_q + 3'h1;
                            shift_q   <= {shift_q[6:0], 1'b0};                      // R12
                            if (!crc_phase_q)
                                crc_q <= crc_nxt;
                        end
                        if (byte_end)
                        begin
                            if (buf_full_q)
                            begin
                                shift_q   <= tx_data_buffer_q;                      // R14
                                saved_q   <= tx_data_buffer_q;
                                ev_load_q <= 1'b1;
                            end
                            else if (tbc_q == 8'h00 && crc_en && !crc_phase_q)       // R15
                            begin
                                // type I/II responses must run with crc disabled
                                shift_q     <= ~crc_nxt;                            // R3 R4
                                crc_phase_q <= 1'b1;
                            end
                            else
                            begin
                                state_q <= ST_EOF;                                  // R5
                                pin_q   <= 1'b0;
                            end
                        end
                    end
                    ST_RETRY:
                    begin
                        if (rx_edge && edge_cnt_q == 4'h1)
                        begin
                            state_q   <= ST_BITS;
                            tmr_q     <= 10'h000;
                            shift_q   <= saved_q;
                            bit_idx_q <= 3'h0;
                            lvl_q     <= 1'b0;
                            pin_q     <= 1'b0;
                        end
                        else if (rx_edge)
                            edge_cnt_q <= edge_cnt_q - 4'h1;
                        else if (!rx_q && rx_low_us_q >= dur_eod)
                        begin
                            // winner ended its response, our slot is gone
                            state_q   <= ST_IDLE;
                            ev_lost_q <= 1'b1;
                        end
                    end
                    ST_EOF:
                    begin
                        // low covers end of data, end of frame and restart gap
                        pin_q <= 1'b0;                                              // R8
                        if (tmr_done)
                        begin
                            state_q   <= ST_IDLE;
                            ev_done_q <= 1'b1;
                        end
                    end
                    ST_BREAK:
                    begin
                        pin_q <= 1'b1;
                        if (tmr_done)                                               // R11
                        begin
                            state_q      <= ST_IDLE;
                            pin_q        <= 1'b0;
                            ev_done_q    <= 1'b1;
                            ev_brk_end_q <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

endmodule

// ---- src/vpw_pkg.sv ----
// constants, register layouts and states of the pulse-width bus transmitter
package vpw_pkg;

    // clock and microsecond tick
    localparam int          CLK_HZ       = 25_000_000;
    localparam int          TICK_CYC     = CLK_HZ / 1_000_000;
    localparam logic [4:0]  TICK_LAST    = 5'(TICK_CYC - 1);

    // symbol durations in microseconds, normal speed then quad speed; break times serve both speeds
    localparam int          SHORT_N_US   = 64;
    localparam int          SHORT_Q_US   = 16;
    localparam int          LONG_N_US    = 128;
    localparam int          LONG_Q_US    = 32;
    localparam int          SOF_N_US     = 200;
    localparam int          SOF_Q_US     = 50;
    localparam int          EOD_N_US     = 200;
    localparam int          EOD_Q_US     = 50;
    localparam int          EOF_N_US     = 280;
    localparam int          EOF_Q_US     = 70;
    localparam int          NEWSOF_N_US  = 320;
    localparam int          NEWSOF_Q_US  = 80;
    localparam int          BRK_DET_US   = 240;
    localparam int          BRK_SHORT_US = 300;
    localparam int          BRK_LONG_US  = 768;
    // settle time before the line is compared against the driven low
    localparam int          ARB_SAMPLE_US = 4;

    // crc-8 generator
    localparam logic [7:0]  CRC_POLY     = 8'h1d;
    localparam logic [7:0]  CRC_INIT     = 8'hff;

    // register byte offsets
    localparam logic [7:0]  OFS_GCR      = 8'h00;
    localparam logic [7:0]  OFS_ISR      = 8'h04;
    localparam logic [7:0]  OFS_MCR      = 8'h08;
    localparam logic [7:0]  OFS_ICR      = 8'h0c;
    localparam logic [7:0]  OFS_TDB      = 8'h10;
    localparam logic [7:0]  OFS_TBC      = 8'h14;

    typedef struct packed {
        logic crc_disable;
        logic quad_speed_select;
        logic type2_response_mode;
        logic norm_bit_polarity;
        logic rsvd3;
        logic send_break;
        logic tx_inframe_response_mode;
        logic rsvd0;
    } vpw_gcr_t;

    typedef struct packed {
        logic       arb_lost_flag;
        logic       tx_idle_flag;
        logic       tx_buffer_empty_flag;
        logic [4:0] rsvd;
    } vpw_isr_t;

    typedef struct packed {
        logic       long_break_select;
        logic [2:0] rsvd6;
        logic       tx_dma_enable;
        logic [2:0] rsvd2;
    } vpw_mcr_t;

    typedef struct packed {
        logic       arb_lost_irq_enable;
        logic       rsvd6;
        logic       tx_buffer_empty_irq_enable;
        logic [4:0] rsvd;
    } vpw_icr_t;

    localparam vpw_gcr_t    GCR_RST      = vpw_gcr_t'(8'h00);
    localparam vpw_isr_t    ISR_RST      = vpw_isr_t'(8'h60);
    localparam vpw_mcr_t    MCR_RST      = vpw_mcr_t'(8'h00);
    localparam vpw_icr_t    ICR_RST      = vpw_icr_t'(8'h00);
    localparam logic [7:0]  TBC_RST      = 8'h00;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_WAIT_BUS,
        ST_WAIT_EOD,
        ST_SOF,
        ST_NORM,
        ST_BITS,
        ST_EOF,
        ST_RETRY,
        ST_BREAK
    } vpw_state_t;

endpackage

// ---- verif/vpw_bus_node.sv ----
// other bus node: wired line where a high level dominates
`timescale 1ns/1ps
module vpw_bus_node (
    input  wire logic tx_i,
    input  wire logic jam_i,
    output logic      line_o
);
    assign line_o = tx_i | jam_i;
endmodule

// ---- verif/vpw_bus_transmitter_bench.sv ----
// self-checking bench for the pulse-width bus transmitter
`timescale 1ns/1ps
module vpw_bus_transmitter_bench;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, jam = 0, b;
    logic [7:0]  adr = '0, d = 8'ha5, c = vpw_pkg::CRC_INIT;
    logic [3:0]  sel = '0;
    logic [31:0] dat = '0, dat_o, q;
    logic        ack, pin, dma, irq, line;
    int          err_total = 0, checks_done = 0, n;
    always #20 clk_i = ~clk_i;
    vpw_bus_node i_node (.tx_i(pin), .jam_i(jam), .line_o(line));
    vpw_bus_transmitter i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .rx_line_i(line), .tx_data_pin_o(pin), .tx_dma_req_o(dma),
        .tx_irq_req_o(irq));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic fail_out;
        err_total++;
        $display("MISMATCH wait exp done seen timeout");
        end_of_test;
    endtask
    task automatic chk(string s, logic [31:0] v, logic [31:0] e);
        checks_done++;
        if (v !== e)
        begin
            err_total++;
            $display("MISMATCH %s exp %h seen %h", s, e, v);
        end
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [7:0] x);
        int k = 0;
        @(posedge clk_i);
        {cyc, stb, we, sel, adr, dat} <= {2'b11, w, 4'h1, a, 24'h0, x};
        do @(posedge clk_i); while (ack !== 1'b1 && k++ < 100);
        q = dat_o;
        {cyc, stb} <= 2'b00;
        if (k >= 100)
            fail_out;
    endtask
    task automatic rdc(logic [7:0] a, logic [7:0] e, string s);
        bus(0, a, 8'h00);
        chk(s, q, {24'h0, e});
    endtask
    // cycles until the pin changes level
    task automatic meas;
        logic v = pin;
        n = 0;
        while (pin === v && n++ < 20000) @(posedge clk_i);
        if (n >= 20000)
            fail_out;
    endtask
    // tick phase may shift either edge by up to one microsecond
    function automatic logic near(int e);
        return n > e - 40 && n < e + 40;
    endfunction
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        rdc(8'h04, 8'h60, "isr");
        rdc(8'h00, 8'h00, "gcr");
        rdc(8'h30, 8'h00, "unmapped");
        $display("reset test done");
        bus(1, 8'h00, 8'h40);
        bus(1, 8'h14, 8'h01);
        bus(1, 8'h10, d);
        rdc(8'h14, 8'h00, "tbc");
        meas;
        meas;
        chk("sof", near(1250), 1);
        for (int i = 15; i >= 0; i--)
        begin
            // data bits, then the inverted crc byte, all msb first
            b = i > 7 ? d[i-8] : ~c[7];
            c = {c[6:0], 1'b0} ^ (i > 7 && c[7] ^ b ? vpw_pkg::CRC_POLY : 8'h00);
            meas;
            chk("bit", near(b ^ i[0] ? 400 : 800), 1);
        end
        n = 0;
        do bus(0, 8'h04, 8'h00); while (q !== 32'h60 && n++ < 5000);
        chk("idle", q, 32'h60);
        $display("frame test done");
        bus(1, 8'h08, 8'h08);
        bus(1, 8'h0c, 8'h80);
        bus(1, 8'h14, 8'h01);
        bus(1, 8'h10, 8'h00);
        meas;
        meas;
        repeat (250) @(posedge clk_i);
        chk("dma", dma, 1);
        jam <= 1;
        repeat (100) @(posedge clk_i);
        jam <= 0;
        rdc(8'h04, 8'he0, "arb isr");
        rdc(8'h08, 8'h00, "dma en");
        chk("irq", irq, 1);
        bus(1, 8'h04, 8'h80);
        rdc(8'h04, 8'h60, "arb clr");
        chk("irq", irq, 0);
        $display("arbitration test done");
        bus(1, 8'h00, 8'h44);
        meas;
        meas;
        chk("break", near(7500), 1);
        rdc(8'h00, 8'h00, "gcr");
        chk("break end", pin, 0);
        $display("break test done");
        end_of_test;
    end
endmodule

// ---- verif/vpw_tx_props.sv ----
// port assertions for the pulse-width bus transmitter
`timescale 1ns/1ps
module vpw_tx_props
    import vpw_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        rx_line_i,
    input wire logic        tx_data_pin_o,
    input wire logic        tx_dma_req_o,
    input wire logic        tx_irq_req_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [15:0] hi_q;
    // saturating, so a stuck pin cannot wrap into a pass
    always_ff @(posedge clk_i)
        hi_q <= (rst_i || !tx_data_pin_o) ? '0 : hi_q + 16'(hi_q != '1);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    a_ack_follows: assert property (s_req |=> wb_ack_o) else $error("request not acked");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> !wb_ack_o)
        else $error("ack without request");
    a_dat_upper: assert property (wb_dat_o[31:8] == '0) else $error("upper read bits set");
    a_rst_quiet: assert property ($past(rst_i) |-> !wb_ack_o && !tx_data_pin_o && wb_dat_o == '0)
        else $error("outputs active after reset");
    a_rst_req_low: assert property ($past(rst_i) |-> !tx_irq_req_o && !tx_dma_req_o)
        else $error("requests active after reset");
    // shortest high is a quad-speed short bit, 400 cycles, less 40 cycles of margin
    a_high_width: assert property ($fell(tx_data_pin_o) && !$past(rst_i) |-> hi_q >= 16'd360)
        else $error("high pulse too short");
    a_high_bounded: assert property (hi_q <= 16'd19250) else $error("high beyond long break");
endmodule
bind vpw_bus_transmitter vpw_tx_props i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_line_i(rx_line_i),
    .tx_data_pin_o(tx_data_pin_o), .tx_dma_req_o(tx_dma_req_o), .tx_irq_req_o(tx_irq_req_o));
